// >>> rtl/ibgs_top.sv
// baud rate generator and bus state readback with an avalon-mm slave
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "ibgs_params.svh"

// Overview of operation
// - reload is high byte over low byte
// - bit rate is clock over four reloads
// - zero reload divides as 65536
// - diagnostic_mode read of high gives counter high
// - diagnostic_mode read of low gives counter low
// - state register read-only, flags or state code
// - ack valid set after sent byte answered
// - ack valid cleared on next byte, stop, restart
// - ack flag holds last byte's response
// - address flag high during address transfer
// - data flag high during data transfer
// - ten-bit flag from 11110b prefix on a master start request, cleared after address
// - restart flag: zero stop, one restart
// - clock output flag shows driven level
// - busy flag high while transaction runs
// - diagnostic_mode state: main nibble over substate nibble

module ibgs_top #(
  parameter int AW = `IBGS_AW,
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // avalon-mm slave
  input  wire logic [AW-1:0]     avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // bus engine side
  input  wire ibgs_pkg::ibgs_evt_t engine_evt,
  output logic                   rate_tick,
  output logic [1:0]             rate_phase,
  output logic                   diagnostic_mode,
  output logic [CW-1:0]          rate_reload_value
);

  import ibgs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire           hit_brh   = (avs_address == AW'(`IBGS_BADDR_BRH));
  wire           hit_brl   = (avs_address == AW'(`IBGS_BADDR_BRL));
  wire           hit_state = (avs_address == AW'(`IBGS_BADDR_STATE));
  wire           hit_mode  = (avs_address == AW'(`IBGS_BADDR_MODE));
  wire           lane0     = avs_byteenable[0];

  ibgs_bus_state_t bus_state_r;
  ibgs_bus_state_t bus_state_nxt;
  logic            waitreq_r;
  logic [31:0]     rdata_r;
  logic [31:0]     rdata_nxt;

  wire             req       = avs_read || avs_write;
  // a write lands at the edge where waitrequest is seen low
  wire             commit    = req && (bus_state_r == IBGS_BUS_ANSWER);
  wire             wr_commit = commit && avs_write && lane0;
  wire             wr_brh    = wr_commit && hit_brh;
  wire             wr_brl    = wr_commit && hit_brl;
  wire             wr_mode   = wr_commit && hit_mode;

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [7:0] reload_high_byte_r;
  logic [7:0] reload_low_byte_r;
  logic       diagnostic_mode_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      reload_high_byte_r <= `IBGS_BRH_RST;
      reload_low_byte_r  <= `IBGS_BRL_RST;
      diagnostic_mode_r             <= `IBGS_MODE_RST;
    end else begin
      if (wr_brh) begin
        reload_high_byte_r <= avs_writedata[7:0];
      end
      if (wr_brl) begin
        reload_low_byte_r <= avs_writedata[7:0];
      end
      if (wr_mode) begin
        diagnostic_mode_r <= avs_writedata[`IBGS_BIT_DIAGNOSTIC_MODE];
      end
    end
  end

  wire [CW-1:0] reload_w = {reload_high_byte_r, reload_low_byte_r};

  // counter restarts one cycle after a reload byte changes
  logic reload_wr_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      reload_wr_r <= 1'b0;
    end else begin
      reload_wr_r <= wr_brh || wr_brl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate generator

  logic [CW-1:0] rate_count;

  ibgs_rate_gen #(
    .CW      (CW)
  ) u_rate_gen (
    .clk     (clk),
    .srst    (srst),
    .reload  (reload_w),
    .restart (reload_wr_r),
    .count   (rate_count),
    .tick    (rate_tick),
    .phase   (rate_phase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus status flags

  logic ack_valid_flag_r;
  logic ack_r;
  logic address_phase_flag_r;
  logic data_phase_flag_r;
  logic ten_bit_address_flag_r;
  logic restart_flag_r;
  logic clock_output_level_r;
  logic bus_busy_r;
  logic [3:0] main_state_nibble_r;
  logic [3:0] substate_nibble_r;

  wire ack_valid_flag_set   = engine_evt.ack_evt && engine_evt.transmitting;
  wire ack_valid_flag_clr   = engine_evt.tx_byte_start || engine_evt.stop_evt || engine_evt.restart_evt;
  wire tenb_set   = engine_evt.start_req && engine_evt.master &&
                    (engine_evt.addr_hi5 == `IBGS_TENB_PREFIX);
  wire stop_restart_event_evt   = engine_evt.stop_evt || engine_evt.restart_evt;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_valid_flag_r       <= 1'b0;
      ack_r                  <= 1'b0;
      ten_bit_address_flag_r <= 1'b0;
      restart_flag_r         <= 1'b0;
    end else begin
      // a set in the same cycle as a clear wins
      if (ack_valid_flag_set) begin
        ack_valid_flag_r <= 1'b1;
      end else if (ack_valid_flag_clr) begin
        ack_valid_flag_r <= 1'b0;
      end
      if (engine_evt.ack_evt) begin
        ack_r <= engine_evt.ack_value;
      end
      if (tenb_set) begin
        ten_bit_address_flag_r <= 1'b1;
      end else if (engine_evt.addr_sent) begin
        ten_bit_address_flag_r <= 1'b0;
      end
      if (stop_restart_event_evt) begin
        restart_flag_r <= engine_evt.restart_evt;
      end
    end
  end

  // live levels tracked one cycle behind the engine
  always_ff @(posedge clk) begin
    if (srst) begin
      address_phase_flag_r <= 1'b0;
      data_phase_flag_r    <= 1'b0;
      clock_output_level_r <= 1'b1;
      bus_busy_r           <= 1'b0;
      main_state_nibble_r  <= 4'h0;
      substate_nibble_r    <= 4'h0;
    end else begin
      address_phase_flag_r <= engine_evt.addr_phase;
      data_phase_flag_r    <= engine_evt.data_phase;
      clock_output_level_r <= engine_evt.scl_drive;
      bus_busy_r           <= engine_evt.bus_busy;
      main_state_nibble_r  <= engine_evt.main_state;
      substate_nibble_r    <= engine_evt.substate;
    end
  end

  logic [7:0] status_flags;

  always_comb begin
    status_flags                     = 8'h00;
    status_flags[`IBGS_BIT_ACK_VALID_FLAG]     = ack_valid_flag_r;
    status_flags[`IBGS_BIT_ACK]      = ack_r;
    status_flags[`IBGS_BIT_AS]       = address_phase_flag_r;
    status_flags[`IBGS_BIT_DS]       = data_phase_flag_r;
    status_flags[`IBGS_BIT_TENB]     = ten_bit_address_flag_r;
    status_flags[`IBGS_BIT_RESTART_FLAG]     = restart_flag_r;
    status_flags[`IBGS_BIT_CLOCK_OUTPUT_LEVEL]   = clock_output_level_r;
    status_flags[`IBGS_BIT_BUSY]     = bus_busy_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and handshake

  wire [7:0] diagnostic_mode_code  = {main_state_nibble_r, substate_nibble_r};
  wire [7:0] brh_read   = diagnostic_mode_r ? rate_count[15:8] : reload_high_byte_r;
  wire [7:0] brl_read   = diagnostic_mode_r ? rate_count[7:0] : reload_low_byte_r;
  wire [7:0] state_read = diagnostic_mode_r ? diagnostic_mode_code : status_flags;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_brh) begin
      rdata_nxt[7:0] = brh_read;
    end else if (hit_brl) begin
      rdata_nxt[7:0] = brl_read;
    end else if (hit_state) begin
      rdata_nxt[7:0] = state_read;
    end else if (hit_mode) begin
      rdata_nxt[`IBGS_BIT_DIAGNOSTIC_MODE] = diagnostic_mode_r;
    end
  end

  always_comb begin
    bus_state_nxt = bus_state_r;
    unique case (bus_state_r)
      IBGS_BUS_IDLE: begin
        if (req) begin
          bus_state_nxt = IBGS_BUS_ANSWER;
        end
      end
      IBGS_BUS_ANSWER: begin
        bus_state_nxt = IBGS_BUS_IDLE;
      end
      default: begin
        bus_state_nxt = IBGS_BUS_IDLE;
      end
    endcase
  end

  // one wait cycle keeps read data a clean flop output
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_state_r <= IBGS_BUS_IDLE;
      waitreq_r   <= 1'b1;
      rdata_r     <= 32'h0000_0000;
    end else begin
      bus_state_r <= bus_state_nxt;
      waitreq_r   <= !(req && (bus_state_r == IBGS_BUS_IDLE));
      if (req && (bus_state_r == IBGS_BUS_IDLE) && avs_read) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign avs_readdata      = rdata_r;
  assign avs_waitrequest   = waitreq_r;
  assign diagnostic_mode   = diagnostic_mode_r;
  assign rate_reload_value = reload_w;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // period measurement between ticks
  logic [16:0] gap_r;
  logic        stable_r;
  wire  [16:0] eff_period = (reload_w == 16'h0000) ? `IBGS_ZERO_PERIOD : {1'b0, reload_w};

  always_ff @(posedge clk) begin
    if (srst) begin
      gap_r    <= 17'h00001;
      stable_r <= 1'b0;
    end else begin
      gap_r    <= rate_tick ? 17'h00001 : gap_r + 17'h00001;
      if (reload_wr_r || wr_brh || wr_brl) begin
        stable_r <= 1'b0;
      end else if (rate_tick) begin
        stable_r <= 1'b1;
      end
    end
  end

  sequence s_rd_taken(hit);
    avs_read && hit && bus_state_r == IBGS_BUS_IDLE;
  endsequence

  sequence s_answer;
    !avs_waitrequest;
  endsequence

  a_tick_period: assert property (@(posedge clk) disable iff (srst)
    rate_tick && stable_r && reload_w != 16'h0000 |-> gap_r == eff_period)
    else $error("tick spacing differs from reload value");

  a_zero_reload: assert property (@(posedge clk) disable iff (srst)
    rate_tick && stable_r && reload_w == 16'h0000 |-> gap_r == `IBGS_ZERO_PERIOD)
    else $error("zero reload did not give 65536 cycles");

  a_reload_concat: assert property (@(posedge clk) disable iff (srst)
    wr_brh |=> rate_reload_value[15:8] == $past(avs_writedata[7:0]))
    else $error("high byte not placed in reload bits 15 to 8");

  a_diagnostic_mode_high_rd: assert property (@(posedge clk) disable iff (srst)
    s_rd_taken(hit_brh) ##0 diagnostic_mode_r |=> avs_readdata[7:0] == $past(rate_count[15:8]) ##0 s_answer)
    else $error("diagnostic high read not counter bits");

  a_diagnostic_mode_low_rd: assert property (@(posedge clk) disable iff (srst)
    s_rd_taken(hit_brl) ##0 diagnostic_mode_r |=> avs_readdata[7:0] == $past(rate_count[7:0]) ##0 s_answer)
    else $error("diagnostic low read not counter bits");

  a_state_read: assert property (@(posedge clk) disable iff (srst)
    s_rd_taken(hit_state) |=> avs_readdata[7:0] == $past(diagnostic_mode_r ? diagnostic_mode_code : status_flags))
    else $error("state register read mismatch");

  a_state_ro: assert property (@(posedge clk) disable iff (srst)
    wr_commit && hit_state |=> $stable(reload_w) && $stable(diagnostic_mode_r))
    else $error("write to state register changed something");

  a_ack_valid_flag_set: assert property (@(posedge clk) disable iff (srst)
    ack_valid_flag_set |=> ack_valid_flag_r && ack_r == $past(engine_evt.ack_value))
    else $error("ack valid or ack not set after answered byte");

  a_ack_valid_flag_clear: assert property (@(posedge clk) disable iff (srst)
    ack_valid_flag_clr && !ack_valid_flag_set |=> !ack_valid_flag_r)
    else $error("ack valid not cleared");

  a_ten_bit: assert property (@(posedge clk) disable iff (srst)
    tenb_set || (ten_bit_address_flag_r && !engine_evt.addr_sent) |=> ten_bit_address_flag_r)
    else $error("ten-bit flag not set on prefix");

  a_ten_bit_clr: assert property (@(posedge clk) disable iff (srst)
    engine_evt.addr_sent && !tenb_set |=> !ten_bit_address_flag_r)
    else $error("ten-bit flag not cleared after address");

  a_restart_flag: assert property (@(posedge clk) disable iff (srst)
    stop_restart_event_evt |=> restart_flag_r == $past(engine_evt.restart_evt))
    else $error("restart flag wrong after stop or restart");

  a_live_levels: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> {address_phase_flag_r, data_phase_flag_r, clock_output_level_r, bus_busy_r} ==
             $past({engine_evt.addr_phase, engine_evt.data_phase, engine_evt.scl_drive, engine_evt.bus_busy}))
    else $error("live bus flags lag wrongly");

  a_bus_answer: assert property (@(posedge clk) disable iff (srst)
    req && bus_state_r == IBGS_BUS_IDLE |=> s_answer ##1 avs_waitrequest)
    else $error("avalon answer not after one wait cycle");

endmodule

// >>> pkg/ibgs_params.svh
// offsets, field positions, reset values and widths of the rate generator and bus status block
`ifndef IBGS_PARAMS_SVH
`define IBGS_PARAMS_SVH

// register indices as printed; the byte address is four times the index
`define IBGS_IDX_BRH       24'hFFE243
`define IBGS_IDX_BRL       24'hFFE244
`define IBGS_IDX_STATE     24'hFFE245
`define IBGS_IDX_MODE      24'hFFE250
`define IBGS_AW            26
`define IBGS_BADDR_BRH     {`IBGS_IDX_BRH, 2'b00}
`define IBGS_BADDR_BRL     {`IBGS_IDX_BRL, 2'b00}
`define IBGS_BADDR_STATE   {`IBGS_IDX_STATE, 2'b00}
`define IBGS_BADDR_MODE    {`IBGS_IDX_MODE, 2'b00}

// reset values
`define IBGS_BRH_RST       8'hFF
`define IBGS_BRL_RST       8'hFF
`define IBGS_MODE_RST      1'b0

// status field positions
`define IBGS_BIT_ACK_VALID_FLAG      7
`define IBGS_BIT_ACK       6
`define IBGS_BIT_AS        5
`define IBGS_BIT_DS        4
`define IBGS_BIT_TENB      3
`define IBGS_BIT_RESTART_FLAG      2
`define IBGS_BIT_CLOCK_OUTPUT_LEVEL    1
`define IBGS_BIT_BUSY      0
`define IBGS_BIT_DIAGNOSTIC_MODE      0

// ten-bit address prefix and the zero-reload equivalent period
`define IBGS_TENB_PREFIX   5'h1E
`define IBGS_ZERO_PERIOD   17'h10000

`endif

// >>> pkg/ibgs_pkg.sv
// types shared by the rate generator and bus status block
package ibgs_pkg;

  // events and levels from the bus engine, same clock
  typedef struct packed {
    logic       transmitting;
    logic       ack_evt;
    logic       ack_value;
    logic       tx_byte_start;
    logic       stop_evt;
    logic       restart_evt;
    logic       start_req;
    logic       master;
    logic [4:0] addr_hi5;
    logic       addr_sent;
    logic       addr_phase;
    logic       data_phase;
    logic       scl_drive;
    logic       bus_busy;
    logic [3:0] main_state;
    logic [3:0] substate;
  } ibgs_evt_t;

  // avalon slave handshake states, one-hot
  typedef enum logic [1:0] {
    IBGS_BUS_IDLE   = 2'b01,
    IBGS_BUS_ANSWER = 2'b10
  } ibgs_bus_state_t;

endpackage

// >>> rtl/ibgs_rate_gen.sv
// down-counting rate generator producing the quarter-bit tick
`timescale 1ns/1ps
`include "ibgs_params.svh"

module ibgs_rate_gen #(
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // control
  input  wire logic [CW-1:0] reload,
  input  wire logic          restart,
  // timing out
  output logic [CW-1:0]      count,
  output logic               tick,
  output logic [1:0]         phase
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_r;
  logic [1:0]    phase_r;
  wire           expire = (cnt_r == {{(CW-1){1'b0}}, 1'b1});

  // zero wraps through all ones, so it counts as 65536
  assign cnt_nxt = (restart || expire) ? reload : cnt_r - {{(CW-1){1'b0}}, 1'b1};

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r   <= {`IBGS_BRH_RST, `IBGS_BRL_RST};
      tick_r  <= 1'b0;
      phase_r <= 2'h0;
    end else begin
      cnt_r   <= cnt_nxt;
      tick_r  <= expire && !restart;
      // four quarter ticks make one bit period
      if (expire && !restart) begin
        phase_r <= phase_r + 2'h1;
      end
    end
  end

  assign count = cnt_r;
  assign tick  = tick_r;
  assign phase = phase_r;

  a_reload_on_expire: assert property (@(posedge clk) disable iff (srst)
    expire && !restart |=> cnt_r == $past(reload) && tick_r)
    else $error("counter did not reload on expiry");

endmodule

// >>> tb/ibgs_engine_model.sv
// behavioural bus engine feeding event strobes and levels into the block
`timescale 1ns/1ps

module ibgs_engine_model (
  // clock
  input  wire logic          clk,
  // events
  output ibgs_pkg::ibgs_evt_t evt
);
  import ibgs_pkg::*;

  initial begin
    evt = '0;
    evt.scl_drive = 1'b1;
  end

  // levels move just after an edge and stand until the next call
  task automatic set_lvl(input ibgs_evt_t v);
    @(posedge clk);
    evt <= v;
  endtask

  // one-cycle strobe of the masked bits; a real engine never stretches them
  task automatic pulse(input ibgs_evt_t m);
    @(posedge clk);
    evt <= ibgs_evt_t'(evt | m);
    @(posedge clk);
    evt <= ibgs_evt_t'(evt & ~m);
  endtask
endmodule

// >>> tb/tb_i2c_baud_gen_and_status.sv
// self-checking bench for the rate generator and bus status block
`timescale 1ns/1ps
`include "ibgs_params.svh"

module tb_i2c_baud_gen_and_status;
  import ibgs_pkg::*;
  localparam int            AW    = `IBGS_AW;
  localparam logic [AW-1:0] A_BRH = `IBGS_BADDR_BRH;
  localparam logic [AW-1:0] A_BRL = `IBGS_BADDR_BRL;
  localparam logic [AW-1:0] A_ST  = `IBGS_BADDR_STATE;
  localparam logic [AW-1:0] A_MD  = `IBGS_BADDR_MODE;
  localparam logic [AW-1:0] A_BAD = 26'h0000100;
  logic            clk = 1'b0;
  logic            srst = 1'b1;
  logic [AW-1:0]   avs_address = '0;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic [31:0]     avs_writedata = '0;
  logic [3:0]      avs_byteenable = 4'hF;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic            rate_tick;
  logic [1:0]      rate_phase;
  logic            diagnostic_mode;
  logic [15:0]     rate_reload_value;
  ibgs_evt_t       engine_evt;
  ibgs_evt_t       lv;
  ibgs_evt_t       m;
  int              num_errors = 0;
  int              compares = 0;
  logic [31:0]     q;
  logic [7:0]      hb;
  logic [7:0]      lb;
  logic [1:0]      p0;
  logic [1:0]      p1;
  logic            ack_valid_flag_e;
  logic            ack_e;
  logic            rs_e;
  int              n;
  int              c;
  int              k;

  always #2 clk = ~clk;

  ibgs_top i_dut (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .engine_evt(engine_evt), .rate_tick(rate_tick),
    .rate_phase(rate_phase), .diagnostic_mode(diagnostic_mode), .rate_reload_value(rate_reload_value)
  );

  ibgs_engine_model i_eng (.clk(clk), .evt(engine_evt));

  task automatic end_of_test();
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request stands until waitrequest is sampled low, then drops
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [7:0] d, input logic [3:0] be);
    int t;
    t = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    q = avs_readdata;
    if (t >= 50) chk("bus answer", 32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_tick(output int cnt, output logic [1:0] ph);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (rate_tick !== 1'b1 && cnt < 200);
    ph = rate_phase;
  endtask

  function automatic logic [31:0] st_exp(input logic av, input logic ak, input logic tb, input logic rs,
                                         input ibgs_evt_t v);
    return {24'h000000, av, ak, v.addr_phase, v.data_phase, tb, rs, v.scl_drive, v.bus_busy};
  endfunction

  initial begin
    #80000;
    chk("watchdog", 32'h0, 32'h1);
    end_of_test();
  end

  initial begin
    void'($urandom(32'h24DFA1E5));
    lv = '0;
    lv.scl_drive = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    bus(0, A_BRH, 8'h00, 4'hF); chk("brh reset", q, 32'h000000FF);
    bus(0, A_BRL, 8'h00, 4'hF); chk("brl reset", q, 32'h000000FF);
    bus(0, A_ST, 8'h00, 4'hF); chk("state reset", q, 32'h00000002);
    bus(0, A_MD, 8'h00, 4'hF); chk("mode reset", q, 32'h00000000);
    chk("reload port reset", {16'h0000, rate_reload_value}, 32'h0000FFFF);
    ////////////////////////////////////////////////////////////////////////
    for (k = 0; k < 6; k++) begin
      hb = 8'($urandom);
      lb = 8'($urandom);
      bus(1, A_BRH, hb, 4'hF);
      bus(1, A_BRL, lb, 4'hF);
      bus(1, A_BRH, ~hb, 4'hE);
      bus(1, A_BAD, ~lb, 4'hF);
      bus(1, A_ST, 8'hFF, 4'hF);
      bus(0, A_BRH, 8'h00, 4'hF); chk("brh", q, {24'h000000, hb});
      bus(0, A_BRL, 8'h00, 4'hF); chk("brl", q, {24'h000000, lb});
      bus(0, A_BAD, 8'h00, 4'hF); chk("unmapped", q, 32'h00000000);
      chk("reload port", {16'h0000, rate_reload_value}, {16'h0000, hb, lb});
    end
    ////////////////////////////////////////////////////////////////////////
    for (k = 0; k < 3; k++) begin
      n = (k == 0) ? 1 : 5 + int'($urandom % 40);
      bus(1, A_BRH, 8'h00, 4'hF);
      bus(1, A_BRL, 8'(n), 4'hF);
      wait_tick(c, p0);
      wait_tick(c, p0);
      wait_tick(c, p1);
      chk("tick period", c, n);
      chk("phase step", {30'h0, p1}, {30'h0, p0 + 2'd1});
    end
    bus(1, A_BRL, 8'h00, 4'hF);
    // skip the edge that may still carry a tick of the old period
    @(posedge clk);
    c = 0;
    repeat (3000) begin
      @(posedge clk);
      if (rate_tick !== 1'b0) c++;
    end
    chk("zero reload ticks", c, 0);
    bus(1, A_MD, 8'h01, 4'hF);
    bus(0, A_MD, 8'h00, 4'hF); chk("mode", q, 32'h00000001);
    chk("mode port", {31'h0, diagnostic_mode}, 32'h00000001);
    bus(0, A_BRH, 8'h00, 4'hF); chk("zero reload count", {31'h0, q[7:0] >= 8'hF0}, 32'h1);
    lb = 8'h40 + 8'($urandom % 128);
    bus(1, A_BRH, 8'hC0, 4'hF);
    bus(1, A_BRL, lb, 4'hF);
    bus(0, A_BRH, 8'h00, 4'hF); chk("diagnostic_mode count high", q, 32'h000000C0);
    bus(0, A_BRL, 8'h00, 4'hF); chk("diagnostic_mode count low", {31'h0, q[7:0] <= lb && q[7:0] + 8'd24 >= lb}, 32'h1);
    lv.main_state = 4'($urandom);
    lv.substate = 4'($urandom);
    i_eng.set_lvl(lv);
    bus(0, A_ST, 8'h00, 4'hF); chk("diagnostic_mode state", q, {24'h0, lv.main_state, lv.substate});
    bus(1, A_MD, 8'h00, 4'hF);
    ////////////////////////////////////////////////////////////////////////
    rs_e = 1'b0;
    for (k = 0; k < 5; k++) begin
      lv.transmitting = (k < 4);
      lv.bus_busy = 1'b1;
      lv.ack_value = k[0];
      ack_e = k[0];
      i_eng.set_lvl(lv);
      m = '0;
      m.ack_evt = 1'b1;
      i_eng.pulse(m);
      ack_valid_flag_e = (k < 4);
      bus(0, A_ST, 8'h00, 4'hF); chk("ack valid set", q, st_exp(ack_valid_flag_e, ack_e, 1'b0, rs_e, lv));
      m = '0;
      if (k == 1) m.stop_evt = 1'b1;
      else if (k == 2) m.restart_evt = 1'b1;
      else m.tx_byte_start = 1'b1;
      rs_e = (k == 1) ? 1'b0 : (k == 2) ? 1'b1 : rs_e;
      i_eng.pulse(m);
      bus(0, A_ST, 8'h00, 4'hF); chk("ack valid clear", q, st_exp(1'b0, ack_e, 1'b0, rs_e, lv));
    end
    ////////////////////////////////////////////////////////////////////////
    // answer and next-byte start in one cycle: the set wins
    lv.transmitting = 1'b1;
    i_eng.set_lvl(lv);
    m = '0;
    m.ack_evt = 1'b1;
    m.tx_byte_start = 1'b1;
    i_eng.pulse(m);
    ack_e = lv.ack_value;
    bus(0, A_ST, 8'h00, 4'hF); chk("ack valid set wins", q, st_exp(1'b1, ack_e, 1'b0, rs_e, lv));
    m = '0;
    m.tx_byte_start = 1'b1;
    i_eng.pulse(m);
    bus(0, A_ST, 8'h00, 4'hF); chk("ack valid next byte", q, st_exp(1'b0, ack_e, 1'b0, rs_e, lv));
    for (k = 0; k < 3; k++) begin
      lv.master = (k != 2);
      lv.addr_hi5 = (k == 1) ? 5'h1F : 5'h1E;
      i_eng.set_lvl(lv);
      m = '0;
      m.start_req = 1'b1;
      i_eng.pulse(m);
      bus(0, A_ST, 8'h00, 4'hF); chk("ten bit set", q, st_exp(1'b0, ack_e, k == 0, rs_e, lv));
      m = '0;
      m.addr_sent = 1'b1;
      i_eng.pulse(m);
      bus(0, A_ST, 8'h00, 4'hF); chk("ten bit clear", q, st_exp(1'b0, ack_e, 1'b0, rs_e, lv));
    end
    ////////////////////////////////////////////////////////////////////////
    for (k = 0; k < 10; k++) begin
      lv.addr_phase = 1'($urandom);
      lv.data_phase = 1'($urandom);
      lv.scl_drive = 1'($urandom);
      lv.bus_busy = 1'($urandom);
      i_eng.set_lvl(lv);
      bus(0, A_ST, 8'h00, 4'hF); chk("live flags", q, st_exp(1'b0, ack_e, 1'b0, rs_e, lv));
    end
    chk("mode port clear", {31'h0, diagnostic_mode}, 32'h00000000);
    end_of_test();
  end
endmodule
